/* File: flash_ctl_pkg.sv */
// constants shared by the command controller and its link front end
// assumes a 25 MHz system clock; all times are rounded to whole cycles here
package flash_ctl_pkg;

    // ****************************************
    // opcodes
    // ****************************************
    localparam logic [7:0] OPC_RESET_ENABLE = 8'h66;
    localparam logic [7:0] OPC_RESET = 8'h99;
    localparam logic [7:0] OPC_PAUSE = 8'h75;
    localparam logic [7:0] OPC_CONTINUE = 8'h7a;
    localparam logic [7:0] OPC_LOW_POWER_ENTRY = 8'hb9;
    localparam logic [7:0] OPC_WAKE_AND_ID = 8'hab;
    localparam logic [7:0] OPC_SFDP = 8'h5a;

    // arbitrary value, not a real part code
    localparam logic [7:0] DEVICE_ID = 8'h3c;

    // ****************************************
    // frame bit counts
    // ****************************************
    localparam logic [5:0] BITS_OPCODE = 6'h08;
    localparam logic [5:0] BITS_ID_START = 6'h20;
    localparam logic [5:0] BITS_ID_LAST = 6'h27;

    // ****************************************
    // timing, times in ns
    // ****************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int T_RST_NS = 30000;
    localparam int T_DP_NS = 3000;
    localparam int T_RES1_NS = 20000;
    localparam int T_RES2_NS = 30000;
    localparam int T_SUS_NS = 20000;
    localparam int T_RESUME_NS = 200;

    // least times round up, longest times round down
    localparam logic [11:0] CYC_RST = 12'((T_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] CYC_DP = 12'((T_DP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] CYC_RES1 = 12'((T_RES1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] CYC_RES2 = 12'((T_RES2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] CYC_SUS = 12'(T_SUS_NS / CLK_PERIOD_NS);
    localparam logic [11:0] CYC_RESUME = 12'(T_RESUME_NS / CLK_PERIOD_NS);

    // ****************************************
    // controller states
    // ****************************************
    typedef enum logic [4:0] {
        ST_IDLE     = 5'h01,
        ST_RECOVER  = 5'h02,
        ST_DP_ENTRY = 5'h04,
        ST_DPD      = 5'h08,
        ST_WAKE     = 5'h10
    } ctl_state_t;

    localparam int STATE_DPD_BIT = 3;

endpackage

/* File: flash_sync2.sv */
// two flip-flop synchroniser for one level
// assumes the input is a level that stays put for several destination clocks
`timescale 1ns/1ps
`default_nettype none
module flash_sync2 #(
    parameter logic RESET_VAL = 1'b0
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // level
    input wire logic level_i,
    output logic level_o
);

    logic meta;

    // first stage feeds only the second
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta <= RESET_VAL;
            level_o <= RESET_VAL;
        end else begin
            meta <= level_i;
            level_o <= meta;
        end
    end

endmodule // flash_sync2
`default_nettype wire

/* File: flash_link.sv */
// serial link front end on the host serial clock
// assumes the clock only runs inside frames; chip select high clears the bit count
`timescale 1ns/1ps
`default_nettype none
module flash_link (
    // link pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_o,
    // system side
    input wire logic reset_n_i,
    input wire logic id_block_i,
    output logic [7:0] opcode_o,
    output logic [5:0] bits_o,
    output logic frame_tog_o
);
    import flash_ctl_pkg::*;

    logic [5:0] count;
    logic [5:0] next_count;
    logic block_s;

    // refusal level moved onto the link clock
    flash_sync2 #(.RESET_VAL(1'b1)) u_block_sync (
        .clock_i(sclk_i),
        .reset_n_i(reset_n_i),
        .level_i(id_block_i),
        .level_o(block_s)
    );

    // bit count wraps into a repeating id byte window
    always_comb begin
        next_count = count + 6'h01;
        if (count == BITS_ID_LAST) begin
            next_count = BITS_ID_START;
        end
    end

    // count restarts with every frame
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            count <= 6'h00;
        end else begin
            count <= next_count;
        end
    end

    // opcode and frame summary survive chip select rising
    always_ff @(posedge sclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            opcode_o <= 8'h00;
            bits_o <= 6'h00;
            frame_tog_o <= 1'b0;
        end else begin
            if (count < BITS_OPCODE) begin
                opcode_o <= {opcode_o[6:0], mosi_i};
            end
            if (count == 6'h00) begin
                frame_tog_o <= ~frame_tog_o; // one toggle per frame
            end
            bits_o <= next_count;
        end
    end

    // id shifted out msb first on falling edges, repeated
    always_ff @(negedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            miso_o <= 1'b0;
            miso_oe_o <= 1'b0;
        end else begin
            if (count >= BITS_ID_START && opcode_o == OPC_WAKE_AND_ID && !block_s) begin
                miso_oe_o <= 1'b1;
                miso_o <= DEVICE_ID[3'h7 - count[2:0]];
            end else begin
                miso_oe_o <= 1'b0;
                miso_o <= 1'b0;
            end
        end
    end

endmodule // flash_link
`default_nettype wire

/* File: flash_cmd_ctrl.sv */
// command controller: reset, pause/continue, deep power-down, wake and id
// assumes a host serial controller on the link pins and a cycle engine on the side ports
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_ctrl (
    // system clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // link pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_o,
    // cycle engine
    input wire logic cycle_start_i,
    input wire logic cycle_pausable_i,
    input wire logic cycle_done_i,
    input wire logic wel_set_i,
    input wire logic wel_clear_i,
    // status
    output logic progress_flag_o,
    output logic paused_operation_flag_o,
    output logic write_enable_latch_o,
    output logic deep_power_down_o,
    output logic standby_o,
    output logic commands_refused_o,
    // events to the rest of the device
    output logic abort_cycle_o,
    output logic volatile_clear_o,
    output logic sfdp_request_o,
    output logic cmd_valid_o,
    output logic [7:0] cmd_opcode_o
);
    import flash_ctl_pkg::*;

    typedef struct packed {
        ctl_state_t state;
        logic [11:0] timer;
        logic [11:0] flag_timer;
        logic pausing;
        logic resuming;
        logic progress;
        logic paused;
        logic pausable;
        logic write_enable_latch;
        logic armed;
        logic frame_seen;
        logic refused;
        logic standby;
        logic abort;
        logic volatile_clear;
        logic sfdp_req;
        logic cmd_valid;
        logic [7:0] cmd_opcode;
    } ctl_regs_t;

    ctl_regs_t r;
    ctl_regs_t next_r;

    // ****************************************
    // link and crossings
    // ****************************************
    logic [7:0] link_opcode;
    logic [5:0] link_bits;
    logic link_tog;
    logic tog_s;
    logic cs_high_s;
    logic frame_end;
    logic complete;
    logic exact8;
    logic [7:0] op;

    flash_link u_link (
        .sclk_i(sclk_i),
        .cs_n_i(cs_n_i),
        .mosi_i(mosi_i),
        .miso_o(miso_o),
        .miso_oe_o(miso_oe_o),
        .reset_n_i(reset_n_i),
        .id_block_i(r.refused),
        .opcode_o(link_opcode),
        .bits_o(link_bits),
        .frame_tog_o(link_tog)
    );

    flash_sync2 #(.RESET_VAL(1'b1)) u_cs_sync (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .level_i(cs_n_i),
        .level_o(cs_high_s)
    );

    flash_sync2 #(.RESET_VAL(1'b0)) u_tog_sync (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .level_i(link_tog),
        .level_o(tog_s)
    );

    // a frame ends once select is high and a new toggle has arrived;
    // opcode and bit count are frozen by then
    assign frame_end = cs_high_s && (tog_s != r.frame_seen);
    assign op = link_opcode;
    assign complete = link_bits >= BITS_OPCODE;
    assign exact8 = link_bits == BITS_OPCODE;

    // recovery, power-down entry and wake waits refuse every frame
    function automatic logic waiting_state(input ctl_state_t s);
        return s == ST_RECOVER || s == ST_DP_ENTRY || s == ST_WAKE;
    endfunction

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_r = r;
        next_r.abort = 1'b0;
        next_r.volatile_clear = 1'b0;
        next_r.sfdp_req = 1'b0;
        next_r.cmd_valid = 1'b0;

        // state timers
        if (r.timer != 12'h000) begin
            next_r.timer = r.timer - 12'h001;
        end
        unique case (r.state)
            ST_RECOVER: begin
                if (r.timer == 12'h001) begin
                    next_r.state = ST_IDLE;
                end
            end
            ST_DP_ENTRY: begin
                if (r.timer == 12'h001) begin
                    next_r.state = ST_DPD;
                end
            end
            ST_WAKE: begin
                if (r.timer == 12'h001) begin
                    next_r.state = ST_IDLE;
                end
            end
            ST_IDLE, ST_DPD: begin
            end
        endcase

        // pause and continue flag latency
        if (r.flag_timer != 12'h000) begin
            next_r.flag_timer = r.flag_timer - 12'h001;
        end
        if (r.flag_timer == 12'h001 && r.pausing) begin
            next_r.progress = 1'b0;
            next_r.pausing = 1'b0;
        end
        if (r.flag_timer == 12'h001 && r.resuming) begin
            next_r.progress = 1'b1;
            next_r.resuming = 1'b0;
        end

        // self-timed cycle start and completion
        if (cycle_start_i && !r.progress && !r.paused) begin
            next_r.progress = 1'b1;
            next_r.pausable = cycle_pausable_i;
        end
        if (cycle_done_i && r.progress && !r.pausing) begin
            next_r.progress = 1'b0;
            next_r.pausable = 1'b0;
            next_r.write_enable_latch = 1'b0;
        end

        // write enable latch
        if (wel_clear_i) begin
            next_r.write_enable_latch = 1'b0;
        end
        if (wel_set_i) begin
            next_r.write_enable_latch = 1'b1;
        end

        // frame decode
        if (frame_end) begin
            next_r.frame_seen = tog_s;
            next_r.armed = 1'b0;
            if (complete && !waiting_state(r.state)) begin
                if (op == OPC_RESET_ENABLE) begin
                    next_r.armed = 1'b1;
                end
                if (r.state == ST_DPD) begin
                    if (op == OPC_WAKE_AND_ID && !r.progress) begin
                        next_r.state = ST_WAKE;
                        next_r.timer = exact8 ? CYC_RES1 : CYC_RES2;
                    end
                end else begin
                    unique case (op)
                        OPC_PAUSE: begin
                            if (!r.paused && r.progress && r.pausable && !r.resuming) begin
                                next_r.paused = 1'b1;
                                next_r.pausing = 1'b1;
                                next_r.flag_timer = CYC_SUS;
                            end
                        end
                        OPC_CONTINUE: begin
                            if (r.paused && !r.progress) begin
                                next_r.paused = 1'b0;
                                next_r.resuming = 1'b1;
                                next_r.flag_timer = CYC_RESUME;
                            end
                        end
                        OPC_LOW_POWER_ENTRY: begin
                            if (exact8 && !r.progress) begin
                                next_r.state = ST_DP_ENTRY;
                                next_r.timer = CYC_DP;
                            end
                        end
                        OPC_SFDP: begin
                            next_r.sfdp_req = 1'b1;
                        end
                        OPC_WAKE_AND_ID, OPC_RESET_ENABLE, OPC_RESET: begin
                        end
                        default: begin
                            next_r.cmd_valid = 1'b1;
                            next_r.cmd_opcode = op;
                        end
                    endcase
                end
                // reset sequence wins over everything else
                if (op == OPC_RESET && r.armed) begin
                    next_r.state = ST_RECOVER;
                    next_r.timer = CYC_RST;
                    next_r.progress = 1'b0;
                    next_r.paused = 1'b0;
                    next_r.pausable = 1'b0;
                    next_r.pausing = 1'b0;
                    next_r.resuming = 1'b0;
                    next_r.flag_timer = 12'h000;
                    next_r.write_enable_latch = 1'b0;
                    next_r.abort = 1'b1;
                    next_r.volatile_clear = 1'b1;
                    next_r.cmd_valid = 1'b0;
                    next_r.sfdp_req = 1'b0;
                end
            end
        end

        // status levels
        next_r.refused = next_r.progress || waiting_state(next_r.state);
        next_r.standby = cs_high_s && next_r.state == ST_IDLE && !next_r.progress;
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            r <= '{state: ST_IDLE, timer: 12'h000, flag_timer: 12'h000, cmd_opcode: 8'h00, default: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from the state register
    assign progress_flag_o = r.progress;
    assign paused_operation_flag_o = r.paused;
    assign write_enable_latch_o = r.write_enable_latch;
    assign deep_power_down_o = r.state[STATE_DPD_BIT];
    assign standby_o = r.standby;
    assign commands_refused_o = r.refused;
    assign abort_cycle_o = r.abort;
    assign volatile_clear_o = r.volatile_clear;
    assign sfdp_request_o = r.sfdp_req;
    assign cmd_valid_o = r.cmd_valid;
    assign cmd_opcode_o = r.cmd_opcode;

    // ****************************************
    // assertions
    // ****************************************
    localparam int SUS_BOUND = int'(CYC_SUS);
    localparam int RESUME_BOUND = int'(CYC_RESUME);

    a_reset_clears_state: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (frame_end && complete && op == OPC_RESET && r.armed && r.state != ST_RECOVER)
        |=> (!progress_flag_o && !paused_operation_flag_o && !write_enable_latch_o && abort_cycle_o))
        else $error("reset did not clear state");

    a_reset_needs_enable: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (frame_end && op == OPC_RESET && !r.armed && r.state != ST_RECOVER) |=> !abort_cycle_o)
        else $error("reset taken without enable frame");

    a_recover_refuses: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (r.state == ST_RECOVER) |-> commands_refused_o ##1 (!cmd_valid_o && !sfdp_request_o))
        else $error("command accepted during recovery");

    a_pause_accepted: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (frame_end && complete && op == OPC_PAUSE && r.state == ST_IDLE && !r.paused && r.progress
        && r.pausable && !r.resuming) |=> paused_operation_flag_o ##[1:SUS_BOUND] !progress_flag_o)
        else $error("pause flags wrong");

    a_pause_ignored: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (frame_end && op == OPC_PAUSE && !r.progress && !r.paused) |=> !paused_operation_flag_o)
        else $error("pause taken without running cycle");

    a_continue_timing: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (frame_end && complete && op == OPC_CONTINUE && r.state == ST_IDLE && r.paused && !r.progress)
        |=> !paused_operation_flag_o ##[1:RESUME_BOUND] progress_flag_o)
        else $error("continue flags wrong");

    a_dp_needs_eight: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (frame_end && op == OPC_LOW_POWER_ENTRY && !exact8) |=> (r.state != ST_DP_ENTRY || $past(r.state) == ST_DP_ENTRY))
        else $error("power-down taken with wrong length");

    a_dp_busy_refused: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (frame_end && op == OPC_LOW_POWER_ENTRY && r.progress && r.state == ST_IDLE)
        |=> (r.state == ST_IDLE && (progress_flag_o || $past(cycle_done_i) || $past(r.pausing))))
        else $error("power-down disturbed a running cycle");

    a_dpd_ignores: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (r.state == ST_DPD && frame_end && op != OPC_WAKE_AND_ID && op != OPC_RESET)
        |=> (deep_power_down_o && !cmd_valid_o))
        else $error("command obeyed in deep power-down");

endmodule // flash_cmd_ctrl
`default_nettype wire

/* File: flash_host_model.sv */
// host serial controller model: sends whole frames on the link pins
// assumes the bench resolves miso with a pull-up while the device lets go
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
    // link pins
    output logic sclk_o,
    output logic cs_n_o,
    output logic mosi_o,
    input wire logic miso_i
);
    // idle link: clock still, deselected
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // one frame msb first, clock runs only inside it
    task automatic frame(input logic [63:0] tx, input int n, output logic [63:0] rx);
        rx = '0;
        cs_n_o = 1'b0;
        for (int i = 0; i < n; i++) begin
            mosi_o = tx[63-i];
            #15 sclk_o = 1'b1;
            rx = {rx[62:0], miso_i};
            #15 sclk_o = 1'b0;
        end
        mosi_o = ~mosi_o; // released line flips
        #15 cs_n_o = 1'b1; // exact bit count
        #400; // gap keeps frames apart
    endtask
endmodule // flash_host_model
`default_nettype wire

/* File: flash_cmd_ctrl_test.sv */
// self-checking bench for the command controller
// assumes the host model drives the link, bench drives the cycle engine
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_ctrl_test;
    import flash_ctl_pkg::*;
    logic clock_i, reset_n_i, sclk_i, cs_n_i, mosi_i, miso_w, miso_o, miso_oe_o;
    logic cycle_start_i, cycle_pausable_i, cycle_done_i, wel_set_i, wel_clear_i;
    logic progress_flag_o, paused_operation_flag_o, write_enable_latch_o, deep_power_down_o;
    logic standby_o, commands_refused_o, abort_cycle_o, volatile_clear_o, sfdp_request_o, cmd_valid_o;
    logic [7:0] cmd_opcode_o, last_op, op;
    logic [63:0] rx;
    logic [31:0] seed = 32'h9a6a;
    int n_fail, cmp_count, cycles, n_abort, n_clear, n_sfdp, n_cmd, base, w;
    // ****
    // design and host
    // ****
    flash_cmd_ctrl flash_cmd_ctrl_inst (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .sclk_i(sclk_i), .cs_n_i(cs_n_i), .mosi_i(mosi_i), .miso_o(miso_o),
        .miso_oe_o(miso_oe_o), .cycle_start_i(cycle_start_i),
        .cycle_pausable_i(cycle_pausable_i), .cycle_done_i(cycle_done_i),
        .wel_set_i(wel_set_i), .wel_clear_i(wel_clear_i), .progress_flag_o(progress_flag_o),
        .paused_operation_flag_o(paused_operation_flag_o),
        .write_enable_latch_o(write_enable_latch_o), .deep_power_down_o(deep_power_down_o),
        .standby_o(standby_o), .commands_refused_o(commands_refused_o),
        .abort_cycle_o(abort_cycle_o), .volatile_clear_o(volatile_clear_o),
        .sfdp_request_o(sfdp_request_o), .cmd_valid_o(cmd_valid_o), .cmd_opcode_o(cmd_opcode_o));
    flash_host_model flash_host_model_inst (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .mosi_o(mosi_i),
        .miso_i(miso_w));
    // pull-up on the released data line
    assign miso_w = miso_oe_o ? miso_o : 1'b1;
    // system clock
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    // pulse counters and hang guard
    always @(posedge clock_i) begin
        cycles++;
        n_abort += abort_cycle_o;
        n_clear += volatile_clear_o;
        n_sfdp += sfdp_request_o;
        if (cmd_valid_o === 1'b1) begin
            n_cmd++;
            last_op = cmd_opcode_o;
        end
        if (cycles > 20000) begin
            n_fail++;
            report_and_stop;
        end
    end
    // ****
    // helpers
    // ****
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("counts: %0d compares, %0d bad", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // random plain opcode, never a controlled one
    task automatic pick_op(output logic [7:0] o);
        do begin
            seed = xs(seed);
            o = seed[7:0];
        end while (o inside {8'h66, 8'h99, 8'h75, 8'h7a, 8'hb9, 8'hab, 8'h5a});
    endtask
    task automatic send(input logic [7:0] o, input int n);
        flash_host_model_inst.frame({o, 56'h0}, n, rx);
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    task automatic start(input logic p);
        @(negedge clock_i);
        cycle_start_i = 1'b1;
        cycle_pausable_i = p;
        tick(1);
        cycle_start_i = 1'b0;
        tick(2);
    endtask
    task automatic finish_cycle;
        @(negedge clock_i);
        cycle_done_i = 1'b1;
        tick(1);
        cycle_done_i = 1'b0;
        tick(2);
    endtask
    // one pulse on the latch set and clear inputs
    task automatic wel_pulse(input logic s, input logic c);
        @(negedge clock_i);
        wel_set_i = s;
        wel_clear_i = c;
        tick(1);
        {wel_set_i, wel_clear_i} = 2'b00;
        tick(2);
    endtask
    // wait for acceptance again, host keeps cs high meanwhile
    task automatic wait_idle;
        for (w = 0; w < 900 && commands_refused_o !== 1'b0; w++) tick(1);
    endtask
    // ****
    // main sequence
    // ****
    initial begin
        {reset_n_i, cycle_start_i, cycle_pausable_i, cycle_done_i, wel_set_i, wel_clear_i} = '0;
        tick(3);
        reset_n_i = 1'b1;
        tick(4);
        check(progress_flag_o, 0);
        check(standby_o, 1);
        wel_pulse(1'b1, 1'b0);
        wel_pulse(1'b0, 1'b1);
        check(write_enable_latch_o, 0);
        wel_pulse(1'b1, 1'b1);
        check(write_enable_latch_o, 1);
        check(progress_flag_o | paused_operation_flag_o, 0);
        send(OPC_RESET_ENABLE, 8);
        send(OPC_RESET, 8);
        check(8'(n_abort), 1);
        check(8'(n_clear), 1);
        check(write_enable_latch_o, 0);
        send(OPC_SFDP, 8);
        check(8'(n_sfdp), 0);
        wait_idle;
        check(commands_refused_o, 0);
        pick_op(op);
        send(OPC_RESET_ENABLE, 8);
        send(op, 8);
        send(OPC_RESET, 8);
        check(8'(n_abort), 1);
        base = n_cmd;
        for (int k = 0; k < 6; k++) begin
            pick_op(op);
            send(op, 8);
            check(last_op, op);
        end
        check(8'(n_cmd - base), 6);
        send(OPC_SFDP, 8);
        check(8'(n_sfdp), 1);
        $display("test reset and decode done");
        send(OPC_PAUSE, 8);
        check(paused_operation_flag_o, 0);
        start(1'b0);
        check(progress_flag_o, 1);
        check(standby_o, 0);
        send(OPC_PAUSE, 8);
        check(paused_operation_flag_o, 0);
        finish_cycle;
        check(progress_flag_o, 0);
        start(1'b1);
        send(OPC_PAUSE, 8);
        check(paused_operation_flag_o, 1);
        send(OPC_CONTINUE, 8); // continue ignored while progress is still set
        check(paused_operation_flag_o, 1);
        for (w = 0; w < 600 && progress_flag_o !== 1'b0; w++) tick(1);
        check(progress_flag_o, 0);
        send(OPC_CONTINUE, 8);
        tick(2);
        check(paused_operation_flag_o, 0);
        check(progress_flag_o, 1);
        finish_cycle;
        send(OPC_CONTINUE, 8);
        check(progress_flag_o, 0);
        $display("test pause and continue done");
        start(1'b0);
        send(OPC_LOW_POWER_ENTRY, 8);
        send(OPC_WAKE_AND_ID, 48);
        tick(100);
        check(deep_power_down_o, 0);
        check(rx[7:0], 8'hff);
        check(progress_flag_o, 1);
        finish_cycle;
        send(OPC_LOW_POWER_ENTRY, 9);
        tick(100);
        check(deep_power_down_o, 0);
        send(OPC_LOW_POWER_ENTRY, 8);
        check(deep_power_down_o, 0);
        tick(CYC_DP);
        check(deep_power_down_o, 1);
        check(standby_o, 0);
        base = n_cmd;
        pick_op(op);
        send(op, 8);
        send(OPC_SFDP, 8);
        check(8'(n_cmd - base), 0);
        check(8'(n_sfdp), 1);
        send(OPC_WAKE_AND_ID, 8);
        check(commands_refused_o, 1);
        wait_idle;
        check(8'(w > CYC_RES1 - 20 && w < CYC_RES1), 1);
        check(deep_power_down_o, 0);
        send(OPC_LOW_POWER_ENTRY, 8);
        tick(CYC_DP);
        send(OPC_WAKE_AND_ID, 48);
        check(rx[23:16], 8'hff);
        check(rx[15:8], DEVICE_ID);
        check(rx[7:0], DEVICE_ID);
        wait_idle;
        check(8'(w > CYC_RES2 - 20 && w < CYC_RES2), 1);
        $display("test power-down and wake done");
        report_and_stop;
    end
endmodule // flash_cmd_ctrl_test
`default_nettype wire
